/* File: cpu_osc_model.sv */
// far-side model: cpu halt and clear-watchdog events, plus both rc osc
// assumes clk_i is the 50 MHz core clock and rst_i is synchronous high
`timescale 1ns/1ps
module cpu_osc_model #(
    parameter int HS_DLY = 8,
    parameter int LS_DLY = 4
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic hs_osc_on_i,
    input  wire logic ls_clk_on_i,
    output logic      halt_o,
    output logic      clr_wdt_o,
    output logic      hs_ready_o,
    output logic      ls_ready_o
);
    logic [HS_DLY-1:0] hs_sh;
    logic [LS_DLY-1:0] ls_sh;

    initial begin
        halt_o = 1'b0;
        clr_wdt_o = 1'b0;
    end

    // an osc settles a fixed time after enable and drops at once when off
    always_ff @(posedge clk_i) begin
        hs_sh <= (rst_i || !hs_osc_on_i) ? '0 : {hs_sh[HS_DLY-2:0], 1'b1};
        ls_sh <= (rst_i || !ls_clk_on_i) ? '0 : {ls_sh[LS_DLY-2:0], 1'b1};
    end
    assign hs_ready_o = hs_sh[HS_DLY-1];
    assign ls_ready_o = ls_sh[LS_DLY-1];

    // one-cycle instruction event, taken by the controller at the 2nd edge
    task automatic pulse(input logic clr);
        @(posedge clk_i);
        if (clr) clr_wdt_o <= 1'b1;
        else halt_o <= 1'b1;
        @(posedge clk_i);
        halt_o <= 1'b0;
        clr_wdt_o <= 1'b0;
    endtask
endmodule

/* File: pmc_pkg.sv */
// package for the power and operating mode controller
// assumes a single 50 MHz clock domain and a classic wishbone register bus
package pmc_pkg;
    localparam logic [3:0] CLK_CTRL_OFF = 4'h0;
    localparam logic [3:0] OSC_CTRL_OFF = 4'h4;
    localparam logic [3:0] STATUS_OFF   = 4'h8;
    localparam logic [3:0] WAKE_EN_OFF  = 4'hC;
    localparam int SEL_POS      = 5;
    localparam int HS_IDLE_POS  = 1;
    localparam int LS_IDLE_POS  = 0;
    localparam int HS_STB_POS   = 1;
    localparam int HS_EN_POS    = 0;
    localparam int PDF_POS      = 0;
    localparam int TOF_POS      = 1;
    localparam int MODE_POS     = 4;
    localparam logic [2:0] SEL_RESET  = 3'h1;
    localparam logic [2:0] SEL_SUB    = 3'h7;
    localparam logic       HS_EN_RESET = 1'b1;

    typedef enum logic [2:0] {
        MODE_FAST, MODE_SLOW, MODE_SLEEP, MODE_IDLE_SUBCLOCK_ONLY_MODE, MODE_IDLE_BOTH_CLOCKS_MODE, MODE_IDLE_FASTCLOCK_ONLY_MODE
    } mode_e;

    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [3:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_s;
endpackage

/* File: power_mode_controller.sv */
// power and operating mode controller: clock select, halt modes, wake-up
// assumes cpu events are one-cycle pulses on clk_i; pins and osc stable
// indications are asynchronous and are synchronised here
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module power_mode_controller
    import pmc_pkg::*;
#(
    parameter int PORT_W = 8,
    parameter int IRQ_W  = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire wb_req_s           wb_req_i,
    output wb_rsp_s                wb_rsp_o,
    input  wire logic              halt_i,
    input  wire logic              clr_wdt_i,
    input  wire logic              stack_full_i,
    input  wire logic [IRQ_W-1:0]  irq_flag_i,
    input  wire logic [IRQ_W-1:0]  irq_enable_i,
    input  wire logic              wdt_enable_i,
    input  wire logic              wdt_overflow_i,
    input  wire logic [PORT_W-1:0] porta_i,
    input  wire logic              hs_osc_ready_i,
    input  wire logic              ls_osc_ready_i,
    output logic                   cpu_run_o,
    output logic                   resume_o,
    output logic                   vector_o,
    output logic                   pc_sp_reset_o,
    output logic                   wdt_clear_o,
    output logic                   hs_osc_on_o,
    output logic                   ls_clk_on_o,
    output logic                   sysclk_sub_o,
    output logic [2:0]             sysclk_div_o,
    output mode_e                  mode_o
);
    typedef struct packed {
        mode_e             mode;
        logic [2:0]        sysclk_select;
        logic [2:0]        active_sel;
        logic              hs_osc_idle_enable;
        logic              ls_osc_idle_enable;
        logic              hs_en;
        logic              hs_osc_stable_flag;
        logic              power_down_flag;
        logic              watchdog_timeout_flag;
        logic [PORT_W-1:0] porta_wake_enable;
        logic [PORT_W-1:0] pa_s1;
        logic [PORT_W-1:0] pa_s2;
        logic [PORT_W-1:0] pa_prev;
        logic [1:0]        hs_sync;
        logic [1:0]        ls_sync;
        logic [IRQ_W-1:0]  irq_block;
        logic              wake_hold;
        logic              resume;
        logic              vector;
        logic              pc_sp_reset;
        logic              wdt_clear;
        logic              ack;
        logic [31:0]       rdat;
    } state_s;

    state_s st;
    state_s next_st;

    function automatic logic halted(input mode_e m);
        halted = (m != MODE_FAST) && (m != MODE_SLOW);
    endfunction

    logic hs_ok;
    logic ls_ok;
    logic [PORT_W-1:0] pa_fall;
    logic [IRQ_W-1:0]  irq_wake;
    logic wake;
    logic wr;
    logic rd;
    // one halt instruction that the controller accepts this cycle
    logic halt_take;

    assign hs_ok    = st.hs_sync[1];
    assign ls_ok    = st.ls_sync[1];
    // falling edge of the synchronised pin, gated per pin
    assign pa_fall  = st.pa_prev & ~st.pa_s2 & st.porta_wake_enable;
    assign irq_wake = irq_flag_i & ~st.irq_block;
    assign wake     = (|pa_fall) || (|irq_wake) || wdt_overflow_i;
    assign wr = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !st.ack;
    assign rd = wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && !st.ack;
    assign halt_take = halt_i && !halted(st.mode) && !st.wake_hold;

    always_comb begin
        next_st = st;
        next_st.pa_s1   = porta_i;
        next_st.pa_s2   = st.pa_s1;
        next_st.pa_prev = st.pa_s2;
        next_st.hs_sync = {st.hs_sync[0], hs_osc_ready_i};
        next_st.ls_sync = {st.ls_sync[0], ls_osc_ready_i};
        next_st.resume      = 1'b0;
        next_st.vector      = 1'b0;
        next_st.pc_sp_reset = 1'b0;
        next_st.wdt_clear   = 1'b0;
        next_st.ack  = wb_req_i.cyc && wb_req_i.stb && !st.ack;
        next_st.rdat = 32'h0;

        // stable flag follows the oscillator only while it is enabled
        next_st.hs_osc_stable_flag = st.hs_en && hs_ok;

        if (wr && wb_req_i.sel[0]) begin
            if (wb_req_i.adr == CLK_CTRL_OFF) begin
                next_st.sysclk_select = wb_req_i.dat[SEL_POS +: 3];
                next_st.hs_osc_idle_enable = wb_req_i.dat[HS_IDLE_POS];
                next_st.ls_osc_idle_enable = wb_req_i.dat[LS_IDLE_POS];
            end else if (wb_req_i.adr == OSC_CTRL_OFF) begin
                next_st.hs_en = wb_req_i.dat[HS_EN_POS];
                if (wb_req_i.dat[HS_EN_POS] && !st.hs_en) begin
                    next_st.hs_osc_stable_flag = 1'b0;
                end
            end else if (wb_req_i.adr == WAKE_EN_OFF) begin
                next_st.porta_wake_enable = wb_req_i.dat[PORT_W-1:0];
            end
        end
        if (rd) begin
            if (wb_req_i.adr == CLK_CTRL_OFF) begin
                next_st.rdat[SEL_POS +: 3] = st.sysclk_select;
                next_st.rdat[HS_IDLE_POS]  = st.hs_osc_idle_enable;
                next_st.rdat[LS_IDLE_POS]  = st.ls_osc_idle_enable;
            end else if (wb_req_i.adr == OSC_CTRL_OFF) begin
                next_st.rdat[HS_STB_POS] = st.hs_osc_stable_flag;
                next_st.rdat[HS_EN_POS]  = st.hs_en;
            end else if (wb_req_i.adr == STATUS_OFF) begin
                next_st.rdat[PDF_POS]      = st.power_down_flag;
                next_st.rdat[TOF_POS]      = st.watchdog_timeout_flag;
                next_st.rdat[MODE_POS +: 3] = st.mode;
            end else if (wb_req_i.adr == WAKE_EN_OFF) begin
                next_st.rdat[PORT_W-1:0] = st.porta_wake_enable;
            end
        end

        if (clr_wdt_i && !halted(st.mode)) begin
            next_st.power_down_flag = 1'b0;
            next_st.wdt_clear = 1'b1;
        end

        case (st.mode)
            MODE_FAST, MODE_SLOW: begin
                // run-mode clock switching, waits for the target clock
                if (st.sysclk_select == SEL_SUB) begin
                    if (ls_ok) begin
                        next_st.active_sel = SEL_SUB;
                        next_st.mode = MODE_SLOW;
                    end
                end else if (st.hs_en && hs_ok) begin
                    next_st.active_sel = st.sysclk_select;
                    next_st.mode = MODE_FAST;
                end
                if (halt_i && !st.wake_hold) begin
                    next_st.power_down_flag = 1'b1;
                    next_st.watchdog_timeout_flag = 1'b0;
                    next_st.wdt_clear = 1'b1;
                    // pending requests at entry are excluded from wake-up
                    next_st.irq_block = irq_flag_i;
                    case ({st.hs_osc_idle_enable, st.ls_osc_idle_enable})
                        2'b00: next_st.mode = MODE_SLEEP;
                        2'b01: next_st.mode = MODE_IDLE_SUBCLOCK_ONLY_MODE;
                        2'b11: next_st.mode = MODE_IDLE_BOTH_CLOCKS_MODE;
                        default: next_st.mode = MODE_IDLE_FASTCLOCK_ONLY_MODE;
                    endcase
                end
                if (st.wake_hold) begin
                    // original source must be running before cpu restarts
                    if (st.active_sel == SEL_SUB ? ls_ok : hs_ok) begin
                        next_st.wake_hold = 1'b0;
                    end
                end
            end
            default: begin
                if (wake) begin
                    next_st.mode = (st.active_sel == SEL_SUB) ?
                                   MODE_SLOW : MODE_FAST;
                    next_st.wake_hold = 1'b1;
                    if (wdt_overflow_i) begin
                        next_st.watchdog_timeout_flag = 1'b1;
                        next_st.pc_sp_reset = 1'b1;
                    end else if ((|irq_wake) && !(|pa_fall) &&
                                 (|(irq_wake & irq_enable_i)) &&
                                 !stack_full_i) begin
                        next_st.vector = 1'b1;
                    end else begin
                        next_st.resume = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.mode <= MODE_FAST;
            st.sysclk_select <= SEL_RESET;
            st.active_sel <= SEL_RESET;
            st.hs_en <= HS_EN_RESET;
            st.pa_s1 <= '1;
            st.pa_s2 <= '1;
            st.pa_prev <= '1;
        end else begin
            st <= next_st;
        end
    end

    // cpu clock gated in every halted mode and during the restart hold
    assign cpu_run_o     = !halted(st.mode) && !st.wake_hold;
    assign resume_o      = st.resume;
    assign vector_o      = st.vector;
    assign pc_sp_reset_o = st.pc_sp_reset;
    assign wdt_clear_o   = st.wdt_clear;
    assign hs_osc_on_o   = (st.mode == MODE_IDLE_BOTH_CLOCKS_MODE) || (st.mode == MODE_IDLE_FASTCLOCK_ONLY_MODE) ||
                           (!halted(st.mode) && st.hs_en);
    assign ls_clk_on_o   = (st.mode != MODE_SLEEP) && (st.mode != MODE_IDLE_FASTCLOCK_ONLY_MODE);
    assign sysclk_sub_o  = (st.active_sel == SEL_SUB);
    assign sysclk_div_o  = st.active_sel;
    assign mode_o        = st.mode;
    assign wb_rsp_o.ack  = st.ack;
    assign wb_rsp_o.dat  = st.rdat;

    a_halt_sets_pdf: assert property (@(posedge clk_i) disable iff (rst_i)
        (halt_i && !halted(st.mode) && !st.wake_hold) |=>
        st.power_down_flag && !st.watchdog_timeout_flag && halted(st.mode))
        else $error("halt did not set power-down");
    a_sleep_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        (halt_i && !halted(st.mode) && !st.wake_hold &&
         !st.hs_osc_idle_enable && !st.ls_osc_idle_enable) |=>
        st.mode == MODE_SLEEP && !ls_clk_on_o)
        else $error("sleep not entered");
    a_idle_both_clocks_mode_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        (halt_i && !halted(st.mode) && !st.wake_hold &&
         st.hs_osc_idle_enable && st.ls_osc_idle_enable) |=>
        st.mode == MODE_IDLE_BOTH_CLOCKS_MODE && hs_osc_on_o)
        else $error("idle-1 not entered");
    a_halt_clear_wdt: assert property (@(posedge clk_i) disable iff (rst_i)
        (halt_i && !halted(st.mode) && !st.wake_hold) |=> wdt_clear_o)
        else $error("watchdog not cleared on halt");
    a_cpu_stopped: assert property (@(posedge clk_i) disable iff (rst_i)
        halted(st.mode) |-> !cpu_run_o)
        else $error("cpu runs while halted");
    a_wdt_wake: assert property (@(posedge clk_i) disable iff (rst_i)
        (halted(st.mode) && wdt_overflow_i) |=>
        pc_sp_reset_o && st.watchdog_timeout_flag && !halted(st.mode))
        else $error("overflow wake wrong");
    a_clrwdt_pdf: assert property (@(posedge clk_i) disable iff (rst_i)
        (clr_wdt_i && !halted(st.mode)) |=> !st.power_down_flag)
        else $error("power-down flag not cleared");
    a_hold_after_wake: assert property (@(posedge clk_i) disable iff (rst_i)
        (halted(st.mode) && wake) |=> !cpu_run_o)
        else $error("cpu ran before clock stable");
    a_blocked_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        (halted(st.mode) && !wdt_overflow_i && !(|pa_fall) &&
         !(|(irq_flag_i & ~st.irq_block))) |=> halted(st.mode))
        else $error("blocked interrupt woke device");
    a_sub_needs_ls: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(sysclk_sub_o) |-> $past(ls_ok))
        else $error("sub clock taken before stable");
    // entry modes for the two mixed idle-enable settings
    a_idle_subclock_only_mode_entry: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (halt_take && !st.hs_osc_idle_enable && st.ls_osc_idle_enable) |=>
        (st.mode == MODE_IDLE_SUBCLOCK_ONLY_MODE && ls_clk_on_o && !hs_osc_on_o))
        else $error("idle-0 not entered");
    a_idle_fastclock_only_mode_entry: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (halt_take && st.hs_osc_idle_enable && !st.ls_osc_idle_enable) |=>
        (st.mode == MODE_IDLE_FASTCLOCK_ONLY_MODE && hs_osc_on_o && !ls_clk_on_o))
        else $error("idle-2 not entered");
    // run modes never fall into a halted mode without a halt
    a_no_silent_halt: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (!halted(st.mode) && !halt_take) |=> !halted(st.mode))
        else $error("halted without halt instruction");
    a_halt_in_hold: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (halt_i && st.wake_hold && !halted(st.mode)) |=> !halted(st.mode))
        else $error("halt taken during restart hold");
    a_clock_kept: assert property (@(posedge clk_i)
        disable iff (rst_i)
        halted(st.mode) |=> $stable(st.active_sel))
        else $error("clock source changed while halted");
    a_slow_on_sub: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (st.mode == MODE_SLOW) |-> sysclk_sub_o)
        else $error("slow mode not on sub clock");
    a_fast_on_high: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (st.mode == MODE_FAST) |-> !sysclk_sub_o)
        else $error("fast mode on sub clock");
    // stable flag may only be high once the synced ready was seen
    a_stable_cleared: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (wr && wb_req_i.sel[0] && wb_req_i.adr == OSC_CTRL_OFF &&
         wb_req_i.dat[HS_EN_POS] && !st.hs_en) |=> !st.hs_osc_stable_flag)
        else $error("stable flag not cleared on enable");
    a_stable_real: assert property (@(posedge clk_i)
        disable iff (rst_i)
        st.hs_osc_stable_flag |-> $past(hs_ok))
        else $error("stable flag without ready oscillator");
    // wake-up source decoding and priority
    a_any_wake: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (halted(st.mode) && wake) |=> !halted(st.mode))
        else $error("wake event ignored");
    a_pin_wake: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (halted(st.mode) && (|pa_fall) && !wdt_overflow_i) |=>
        (resume_o && !vector_o))
        else $error("pin wake did not resume");
    a_irq_vector: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (halted(st.mode) && !wdt_overflow_i && !(|pa_fall) &&
         (|(irq_wake & irq_enable_i)) && !stack_full_i) |=> vector_o)
        else $error("enabled interrupt not vectored");
    a_irq_resume: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (halted(st.mode) && !wdt_overflow_i && !(|pa_fall) &&
         (|irq_wake) && (!(|(irq_wake & irq_enable_i)) || stack_full_i))
        |=> (resume_o && !vector_o))
        else $error("masked interrupt did not resume");
    a_ovf_keeps_pdf: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (halted(st.mode) && wdt_overflow_i) |=> st.power_down_flag)
        else $error("overflow wake changed power-down flag");
    a_no_run_pcsp: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !halted(st.mode) |=> !pc_sp_reset_o)
        else $error("pc/sp reset outside halted mode");
    a_hold_release: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (st.wake_hold && !halted(st.mode) &&
         (sysclk_sub_o ? ls_ok : hs_ok)) |=> cpu_run_o)
        else $error("cpu held after clock stable");
    c_sleep_wake: cover property (@(posedge clk_i) disable iff (rst_i)
        st.mode == MODE_SLEEP ##1 resume_o);
    c_vector: cover property (@(posedge clk_i) disable iff (rst_i) vector_o);
    c_to_slow: cover property (@(posedge clk_i) disable iff (rst_i)
        st.mode == MODE_FAST ##1 st.mode == MODE_SLOW);
    c_wdt_reset: cover property (@(posedge clk_i) disable iff (rst_i)
        pc_sp_reset_o);
    c_idle_subclock_only_mode_vector: cover property (@(posedge clk_i) disable iff (rst_i)
        st.mode == MODE_IDLE_SUBCLOCK_ONLY_MODE ##1 vector_o);
endmodule

/* File: testbench.sv */
// self-checking bench for the power mode controller
// assumes the cpu/osc model above; wishbone master tasks drive the registers
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end
`define WAITFOR(c) begin n_w = 0; while (!(c) && n_w < 300) begin \
    @(posedge clk_i); #1; n_w++; end end
module testbench;
    import pmc_pkg::*;
    wb_req_s     req;
    wb_rsp_s     rsp;
    logic        clk_i, rst_i, stack_full, wdt_ovf, halt, clr, hs_rdy, ls_rdy;
    logic        cpu_run, resume, vector, pcsp, wdt_clr, hs_on, ls_on, sub;
    logic [7:0]  irq_flag, irq_en, porta;
    logic [2:0]  div;
    mode_e       mode;
    logic [31:0] q;
    int          error_cnt, n_checks, nclr, nres, nvec, npc, n_w;
    logic [1:0]  ens [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
    mode_e       emode [5] = '{MODE_SLEEP, MODE_IDLE_SUBCLOCK_ONLY_MODE, MODE_IDLE_BOTH_CLOCKS_MODE,
                               MODE_IDLE_FASTCLOCK_ONLY_MODE, MODE_SLEEP};

    power_mode_controller i_power_mode_controller (.clk_i(clk_i),
        .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .halt_i(halt),
        .clr_wdt_i(clr), .stack_full_i(stack_full), .irq_flag_i(irq_flag),
        .irq_enable_i(irq_en), .wdt_enable_i(1'b1), .wdt_overflow_i(wdt_ovf),
        .porta_i(porta), .hs_osc_ready_i(hs_rdy), .ls_osc_ready_i(ls_rdy),
        .cpu_run_o(cpu_run), .resume_o(resume), .vector_o(vector),
        .pc_sp_reset_o(pcsp), .wdt_clear_o(wdt_clr), .hs_osc_on_o(hs_on),
        .ls_clk_on_o(ls_on), .sysclk_sub_o(sub), .sysclk_div_o(div),
        .mode_o(mode));
    cpu_osc_model i_cpu_osc_model (.clk_i(clk_i), .rst_i(rst_i),
        .hs_osc_on_i(hs_on), .ls_clk_on_i(ls_on), .halt_o(halt),
        .clr_wdt_o(clr), .hs_ready_o(hs_rdy), .ls_ready_o(ls_rdy));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (wdt_clr === 1'b1) nclr++;
        if (resume === 1'b1) nres++;
        if (vector === 1'b1) nvec++;
        if (pcsp === 1'b1) npc++;
    end

    task automatic wb(input logic we, input logic [3:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 50);
        if (rsp.ack !== 1'b1) error_cnt++;
        q = rsp.dat;
        req <= '0;
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #400000;
        error_cnt++;
        results();
    end

    initial begin
        req = '0; rst_i = 1'b1; stack_full = 1'b0; wdt_ovf = 1'b0;
        irq_flag = 8'h00; irq_en = 8'h00; porta = 8'hFF;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, CLK_CTRL_OFF, 32'h0); `CHK(q, 32'h20)
        wb(1'b0, OSC_CTRL_OFF, 32'h0); `CHK(q, 32'h1)
        wb(1'b0, STATUS_OFF, 32'h0); `CHK(q, 32'h0)
        wb(1'b1, 4'h2, 32'hFF); wb(1'b0, 4'h2, 32'h0); `CHK(q, 32'h0)
        repeat (12) @(posedge clk_i);
        wb(1'b0, OSC_CTRL_OFF, 32'h0); `CHK(q, 32'h3)
        for (int d = 0; d < 7; d++) begin
            wb(1'b1, CLK_CTRL_OFF, 32'(d) << SEL_POS);
            `WAITFOR(div === 3'(d)) `CHK(div, 3'(d))
            `CHK(sub, 1'b0)
        end
        wb(1'b1, CLK_CTRL_OFF, 32'hE0);
        `WAITFOR(sub === 1'b1) `CHK(sub, 1'b1)
        `CHK(mode, MODE_SLOW)
        wb(1'b1, OSC_CTRL_OFF, 32'h0); repeat (4) @(posedge clk_i);
        wb(1'b0, OSC_CTRL_OFF, 32'h0); `CHK(q[1:0], 2'h0)
        wb(1'b1, CLK_CTRL_OFF, 32'h60); wb(1'b1, OSC_CTRL_OFF, 32'h1);
        wb(1'b0, OSC_CTRL_OFF, 32'h0); `CHK(q[1], 1'b0)
        `WAITFOR(mode === MODE_FAST) `CHK(div, 3'h3)
        wb(1'b0, OSC_CTRL_OFF, 32'h0); `CHK(q[1:0], 2'h3)
        wb(1'b1, WAKE_EN_OFF, 32'h4);
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, CLK_CTRL_OFF, {24'h0, 3'h3, 3'h0, ens[i]});
            if (i == 0) begin
                irq_flag <= 8'h10;
                irq_en <= 8'h10;
            end
            nclr = 0; nres = 0; nvec = 0; npc = 0;
            i_cpu_osc_model.pulse(1'b0); #1;
            `CHK(mode, emode[i])
            `CHK(cpu_run, 1'b0)
            `CHK(hs_on, 5'h0C >> i & 1)
            `CHK(ls_on, 5'h06 >> i & 1)
            wb(1'b0, STATUS_OFF, 32'h0); `CHK(q[1:0], 2'h1)
            `CHK(nclr, 1)
            @(posedge clk_i);
            case (i)
                0: begin
                    porta <= 8'hFE;
                    repeat (10) @(posedge clk_i); #1;
                    `CHK(mode, emode[i])
                    @(posedge clk_i); porta <= 8'hFA;
                end
                1: begin irq_en <= 8'h04; irq_flag <= 8'h04; end
                2: irq_flag <= 8'h04;
                3: begin irq_en <= 8'h04; stack_full <= 1'b1;
                   irq_flag <= 8'h04; end
                default: begin @(posedge clk_i); wdt_ovf <= 1'b1;
                   @(posedge clk_i); wdt_ovf <= 1'b0; end
            endcase
            `WAITFOR(mode === MODE_FAST) `CHK(mode, MODE_FAST)
            `CHK(cpu_run, 1'b0)
            `WAITFOR(cpu_run === 1'b1) `CHK(cpu_run, 1'b1)
            `CHK(nres, 5'h0D >> i & 1)
            `CHK(nvec, 5'h02 >> i & 1)
            `CHK(npc, 5'h10 >> i & 1)
            @(posedge clk_i);
            irq_flag <= 8'h00; irq_en <= 8'h00; stack_full <= 1'b0;
            porta <= 8'hFF;
        end
        wb(1'b0, STATUS_OFF, 32'h0); `CHK(q[1:0], 2'h3)
        i_cpu_osc_model.pulse(1'b1);
        wb(1'b0, STATUS_OFF, 32'h0); `CHK(q[0], 1'b0)
        results();
    end
endmodule
